// ---- vga_port_pkg.sv ----
// constants for the legacy display register port decoder
package vga_port_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PORT_W = 16;

  // ----------------------------------------------------------------
  // byte ports, equal to the offset from the mmio base
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_CRTC_INDEX_MONO      = 16'h03b4;
  localparam logic [15:0] PORT_CRTC_DATA_MONO       = 16'h03b5;
  localparam logic [15:0] PORT_STATUS_ONE_MONO      = 16'h03ba;
  localparam logic [15:0] PORT_ATTRIBUTE_WRITE      = 16'h03c0;
  localparam logic [15:0] PORT_ATTRIBUTE_READ       = 16'h03c1;
  localparam logic [15:0] PORT_STATUS_ZERO_MISC     = 16'h03c2;
  localparam logic [15:0] PORT_SEQUENCER_INDEX      = 16'h03c4;
  localparam logic [15:0] PORT_SEQUENCER_DATA       = 16'h03c5;
  localparam logic [15:0] PORT_PALETTE_PIXEL_MASK   = 16'h03c6;
  localparam logic [15:0] PORT_PALETTE_STATE_READ   = 16'h03c7;
  localparam logic [15:0] PORT_PALETTE_WRITE_INDEX  = 16'h03c8;
  localparam logic [15:0] PORT_PALETTE_DATA         = 16'h03c9;
  localparam logic [15:0] PORT_FEATURE_READBACK     = 16'h03ca;
  localparam logic [15:0] PORT_MISC_READBACK        = 16'h03cc;
  localparam logic [15:0] PORT_GRAPHICS_CTRL_INDEX  = 16'h03ce;
  localparam logic [15:0] PORT_GRAPHICS_CTRL_DATA   = 16'h03cf;
  localparam logic [15:0] PORT_CRTC_INDEX_COLOR     = 16'h03d4;
  localparam logic [15:0] PORT_CRTC_DATA_COLOR      = 16'h03d5;
  localparam logic [15:0] PORT_EXTENSION_INDEX      = 16'h03d6;
  localparam logic [15:0] PORT_EXTENSION_DATA       = 16'h03d7;
  localparam logic [15:0] PORT_STATUS_ONE_COLOR     = 16'h03da;

  // ----------------------------------------------------------------
  // indexed groups: depth and populated indices
  // ----------------------------------------------------------------
  localparam int unsigned SEQ_DEPTH  = 8;
  localparam logic [7:0]  SEQ_VALID  = 8'h9f;
  localparam int unsigned GFX_DEPTH  = 25;
  localparam logic [24:0] GFX_VALID  = 25'h10301ff;
  localparam int unsigned ATTR_DEPTH = 21;
  localparam logic [20:0] ATTR_VALID = 21'h1fffff;
  localparam int unsigned CRTC_DEPTH = 25;
  localparam logic [24:0] CRTC_VALID = 25'h1ffffff;
  localparam int unsigned EXT_DEPTH  = 256;

  localparam logic [7:0] CRTC_IDX_MEMORY_READ_LATCH       = 8'h22;
  localparam logic [7:0] CRTC_IDX_ATTRIBUTE_TOGGLE_READBACK = 8'h24;
  localparam int unsigned TOGGLE_READBACK_BIT = 7;

  // ----------------------------------------------------------------
  // reset values and palette access states
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE            = 8'h00;
  localparam logic [1:0] PAL_STATE_WRITE_MODE = 2'h0;
  localparam logic [1:0] PAL_STATE_READ_MODE  = 2'h3;

endpackage : vga_port_pkg

// ---- index_group_if.sv ----
// carrier between the decoder and one indexed register group
`timescale 1ns/100ps
`default_nettype none
interface index_group_if;
  logic       index_we;
  logic       data_we;
  logic [7:0] wdata;
  logic [7:0] index;
  logic [7:0] rdata;
  logic       hit;

  modport bank (input index_we, input data_we, input wdata, output index, output rdata, output hit);
  modport ctrl (output index_we, output data_we, output wdata, input index, input rdata, input hit);
endinterface : index_group_if
`default_nettype wire

// ---- index_group_bank.sv ----
// one indexed register group: index latch plus data array
`timescale 1ns/100ps
`default_nettype none
module index_group_bank #(
  parameter int unsigned      DEPTH = 8,
  parameter logic [DEPTH-1:0] VALID = '1
) (
  input  wire logic  clk_i,
  input  wire logic  arst_n_i,
  index_group_if.bank grp
);

  logic [7:0] index_reg;
  logic [7:0] mem_reg [DEPTH];
  logic       valid_idx;

  // ----------------------------------------------------------------
  // index decode
  // ----------------------------------------------------------------
  // out-of-range indices are held but reach nothing
  always_comb
  begin
    valid_idx = 1'b0;
    if (32'(index_reg) < DEPTH)
    begin
      valid_idx = VALID[index_reg[$clog2(DEPTH)-1:0]];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      index_reg <= vga_port_pkg::RST_BYTE;
    end
    else if (grp.index_we)
    begin
      index_reg <= grp.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < int'(DEPTH); i++)
      begin
        mem_reg[i] <= vga_port_pkg::RST_BYTE;
      end
    end
    else if (grp.data_we && valid_idx)
    begin
      mem_reg[index_reg[$clog2(DEPTH)-1:0]] <= grp.wdata;
    end
  end

  assign grp.index = index_reg;
  assign grp.hit   = valid_idx;
  assign grp.rdata = valid_idx ? mem_reg[index_reg[$clog2(DEPTH)-1:0]] : 8'h00;

endmodule : index_group_bank
`default_nettype wire

// ---- vga_port_register_decode.sv ----
// legacy display register port decoder for i/o and memory space
//
// Behaviour
// - memory accesses decode as offset from mmio base, offset equals port number.
// - the same register set is also decoded in host i/o space.
// - attribute port writes alternate index load and data write via a toggle.
// - port above attribute port reads indexed attribute data; writes ignored.
// - index port write selects which register the group data port reaches.
// - status ports read input status one, writes load feature control.
// - misc port reads input status zero, writes load misc output.
// - misc output readable at its readback port; writes there ignored.
// - feature control readable at its readback port; writes there ignored.
// - palette state port reads access state, writes load read index.
// - palette write index, data and pixel mask are read/write ports.
// - crtc index/data decoded at mono and colour pairs, one register set.
// - extension index and data ports give indexed extension access.
// - sequencer decodes indices zero to four and seven.
// - graphics controller decodes zero to eight plus mapping, page, flags.
// - attribute decodes sixteen palette entries and controls up to index 14h.
// - crtc index 24h reads attribute toggle, 22h reads memory read latch.
`timescale 1ns/100ps
`default_nettype none
module vga_port_register_decode #(
  parameter int unsigned ADDR_W = vga_port_pkg::ADDR_W
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic              io_space_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [ADDR_W-1:0] mmio_base_address_i,
  input  wire logic [7:0]        input_status_zero_i,
  input  wire logic [7:0]        input_status_one_i,
  input  wire logic [7:0]        memory_read_latch_i,
  input  wire logic [7:0]        palette_data_i,
  output logic                   ack_o,
  output logic [7:0]             rdata_o,
  output logic                   palette_data_wr_o,
  output logic                   palette_data_rd_o,
  output logic [7:0]             palette_data_o,
  output logic [7:0]             misc_output_o,
  output logic [7:0]             feature_control_o,
  output logic [7:0]             palette_pixel_mask_o,
  output logic [7:0]             palette_read_index_o,
  output logic [7:0]             palette_write_index_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] offset;
  logic              in_range;
  logic [15:0]       port;
  logic              rd;
  logic              wr;

  // port numbers are sixteen bits; anything above is not ours
  function automatic logic upper_clear(input logic [ADDR_W-1:0] a);
    return (a >> vga_port_pkg::PORT_W) == '0;
  endfunction : upper_clear

  always_comb
  begin
    offset   = io_space_i ? addr_i : addr_i - mmio_base_address_i;
    in_range = upper_clear(offset);
    port     = offset[15:0];
  end

  assign rd = req_i && !we_i && in_range;
  assign wr = req_i && we_i && in_range;

  // ----------------------------------------------------------------
  // indexed groups
  // ----------------------------------------------------------------
  index_group_if seq_if ();
  index_group_if gfx_if ();
  index_group_if attr_if ();
  index_group_if crtc_if ();
  index_group_if ext_if ();

  index_group_bank #(
    .DEPTH (vga_port_pkg::SEQ_DEPTH),
    .VALID (vga_port_pkg::SEQ_VALID)
  ) u_seq (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .grp      (seq_if.bank)
  );

  index_group_bank #(
    .DEPTH (vga_port_pkg::GFX_DEPTH),
    .VALID (vga_port_pkg::GFX_VALID)
  ) u_gfx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .grp      (gfx_if.bank)
  );

  index_group_bank #(
    .DEPTH (vga_port_pkg::ATTR_DEPTH),
    .VALID (vga_port_pkg::ATTR_VALID)
  ) u_attr (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .grp      (attr_if.bank)
  );

  index_group_bank #(
    .DEPTH (vga_port_pkg::CRTC_DEPTH),
    .VALID (vga_port_pkg::CRTC_VALID)
  ) u_crtc (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .grp      (crtc_if.bank)
  );

  index_group_bank #(
    .DEPTH (vga_port_pkg::EXT_DEPTH),
    .VALID ({vga_port_pkg::EXT_DEPTH{1'b1}})
  ) u_ext (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .grp      (ext_if.bank)
  );

  // ----------------------------------------------------------------
  // attribute toggle
  // ----------------------------------------------------------------
  logic attr_toggle_reg;
  logic attr_wr;

  assign attr_wr = wr && (port == vga_port_pkg::PORT_ATTRIBUTE_WRITE);

  // flips on every write to the attribute port, never on reads
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      attr_toggle_reg <= 1'b0;
    end
    else if (attr_wr)
    begin
      attr_toggle_reg <= !attr_toggle_reg;
    end
  end

  // ----------------------------------------------------------------
  // group strobes
  // ----------------------------------------------------------------
  logic crtc_index_port;
  logic crtc_data_port;

  assign crtc_index_port = (port == vga_port_pkg::PORT_CRTC_INDEX_MONO)
                        || (port == vga_port_pkg::PORT_CRTC_INDEX_COLOR);
  assign crtc_data_port  = (port == vga_port_pkg::PORT_CRTC_DATA_MONO)
                        || (port == vga_port_pkg::PORT_CRTC_DATA_COLOR);

  assign seq_if.wdata    = wdata_i;
  assign gfx_if.wdata    = wdata_i;
  assign attr_if.wdata   = wdata_i;
  assign crtc_if.wdata   = wdata_i;
  assign ext_if.wdata    = wdata_i;

  assign seq_if.index_we  = wr && (port == vga_port_pkg::PORT_SEQUENCER_INDEX);
  assign seq_if.data_we   = wr && (port == vga_port_pkg::PORT_SEQUENCER_DATA);
  assign gfx_if.index_we  = wr && (port == vga_port_pkg::PORT_GRAPHICS_CTRL_INDEX);
  assign gfx_if.data_we   = wr && (port == vga_port_pkg::PORT_GRAPHICS_CTRL_DATA);
  assign attr_if.index_we = attr_wr && !attr_toggle_reg;
  assign attr_if.data_we  = attr_wr && attr_toggle_reg;
  assign crtc_if.index_we = wr && crtc_index_port;
  assign crtc_if.data_we  = wr && crtc_data_port;
  assign ext_if.index_we  = wr && (port == vga_port_pkg::PORT_EXTENSION_INDEX);
  assign ext_if.data_we   = wr && (port == vga_port_pkg::PORT_EXTENSION_DATA);

  // ----------------------------------------------------------------
  // direct registers
  // ----------------------------------------------------------------
  logic [7:0] misc_output_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] pixel_mask_reg;
  logic [7:0] read_index_reg;
  logic [7:0] write_index_reg;
  logic [1:0] access_state_reg;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      misc_output_reg <= vga_port_pkg::RST_BYTE;
    end
    else if (wr && (port == vga_port_pkg::PORT_STATUS_ZERO_MISC))
    begin
      misc_output_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      feature_control_reg <= vga_port_pkg::RST_BYTE;
    end
    else if (wr && ((port == vga_port_pkg::PORT_STATUS_ONE_MONO)
                 || (port == vga_port_pkg::PORT_STATUS_ONE_COLOR)))
    begin
      feature_control_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pixel_mask_reg <= vga_port_pkg::RST_BYTE;
    end
    else if (wr && (port == vga_port_pkg::PORT_PALETTE_PIXEL_MASK))
    begin
      pixel_mask_reg <= wdata_i;
    end
  end

  // access state follows whichever palette index was loaded last
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      read_index_reg   <= vga_port_pkg::RST_BYTE;
      write_index_reg  <= vga_port_pkg::RST_BYTE;
      access_state_reg <= vga_port_pkg::PAL_STATE_WRITE_MODE;
    end
    else if (wr && (port == vga_port_pkg::PORT_PALETTE_STATE_READ))
    begin
      read_index_reg   <= wdata_i;
      access_state_reg <= vga_port_pkg::PAL_STATE_READ_MODE;
    end
    else if (wr && (port == vga_port_pkg::PORT_PALETTE_WRITE_INDEX))
    begin
      write_index_reg  <= wdata_i;
      access_state_reg <= vga_port_pkg::PAL_STATE_WRITE_MODE;
    end
  end

  // ----------------------------------------------------------------
  // palette data strobes
  // ----------------------------------------------------------------
  // the palette ram sits outside; it sees a one-cycle strobe per access
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      palette_data_wr_o <= 1'b0;
      palette_data_rd_o <= 1'b0;
      palette_data_o    <= vga_port_pkg::RST_BYTE;
    end
    else
    begin
      palette_data_wr_o <= wr && (port == vga_port_pkg::PORT_PALETTE_DATA);
      palette_data_rd_o <= rd && (port == vga_port_pkg::PORT_PALETTE_DATA);
      if (wr && (port == vga_port_pkg::PORT_PALETTE_DATA))
      begin
        palette_data_o <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] crtc_read;
  logic [7:0] read_value;

  always_comb
  begin
    if (crtc_if.index == vga_port_pkg::CRTC_IDX_MEMORY_READ_LATCH)
    begin
      crtc_read = memory_read_latch_i;
    end
    else if (crtc_if.index == vga_port_pkg::CRTC_IDX_ATTRIBUTE_TOGGLE_READBACK)
    begin
      crtc_read = 8'h00;
      crtc_read[vga_port_pkg::TOGGLE_READBACK_BIT] = attr_toggle_reg;
    end
    else
    begin
      crtc_read = crtc_if.rdata;
    end
  end

  always_comb
  begin
    read_value = 8'h00;
    case (port)
      vga_port_pkg::PORT_CRTC_INDEX_MONO,
      vga_port_pkg::PORT_CRTC_INDEX_COLOR:    read_value = crtc_if.index;
      vga_port_pkg::PORT_CRTC_DATA_MONO,
      vga_port_pkg::PORT_CRTC_DATA_COLOR:     read_value = crtc_read;
      vga_port_pkg::PORT_STATUS_ONE_MONO,
      vga_port_pkg::PORT_STATUS_ONE_COLOR:    read_value = input_status_one_i;
      vga_port_pkg::PORT_ATTRIBUTE_WRITE:     read_value = attr_if.index;
      vga_port_pkg::PORT_ATTRIBUTE_READ:      read_value = attr_if.rdata;
      vga_port_pkg::PORT_STATUS_ZERO_MISC:    read_value = input_status_zero_i;
      vga_port_pkg::PORT_SEQUENCER_INDEX:     read_value = seq_if.index;
      vga_port_pkg::PORT_SEQUENCER_DATA:      read_value = seq_if.rdata;
      vga_port_pkg::PORT_PALETTE_PIXEL_MASK:  read_value = pixel_mask_reg;
      vga_port_pkg::PORT_PALETTE_STATE_READ:  read_value = {6'h00, access_state_reg};
      vga_port_pkg::PORT_PALETTE_WRITE_INDEX: read_value = write_index_reg;
      vga_port_pkg::PORT_PALETTE_DATA:        read_value = palette_data_i;
      vga_port_pkg::PORT_FEATURE_READBACK:    read_value = feature_control_reg;
      vga_port_pkg::PORT_MISC_READBACK:       read_value = misc_output_reg;
      vga_port_pkg::PORT_GRAPHICS_CTRL_INDEX: read_value = gfx_if.index;
      vga_port_pkg::PORT_GRAPHICS_CTRL_DATA:  read_value = gfx_if.rdata;
      vga_port_pkg::PORT_EXTENSION_INDEX:     read_value = ext_if.index;
      vga_port_pkg::PORT_EXTENSION_DATA:      read_value = ext_if.rdata;
      default:                                read_value = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  // every request is answered one cycle later, mapped or not
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ack_o   <= 1'b0;
      rdata_o <= vga_port_pkg::RST_BYTE;
    end
    else
    begin
      ack_o   <= req_i;
      rdata_o <= rd ? read_value : 8'h00;
    end
  end

  assign misc_output_o         = misc_output_reg;
  assign feature_control_o     = feature_control_reg;
  assign palette_pixel_mask_o  = pixel_mask_reg;
  assign palette_read_index_o  = read_index_reg;
  assign palette_write_index_o = write_index_reg;

endmodule : vga_port_register_decode
`default_nettype wire

// ---- vga_port_register_decode_checker.sv ----
// assertions on the decoder host port and its register outputs
`timescale 1ns/100ps
`default_nettype none
module vga_port_register_decode_checker #(
  parameter int unsigned ADDR_W = 32
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic              io_space_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [ADDR_W-1:0] mmio_base_address_i,
  input  wire logic [7:0]        input_status_zero_i,
  input  wire logic [7:0]        input_status_one_i,
  input  wire logic              ack_o,
  input  wire logic [7:0]        rdata_o,
  input  wire logic              palette_data_wr_o,
  input  wire logic [7:0]        palette_data_o,
  input  wire logic [7:0]        misc_output_o,
  input  wire logic [7:0]        feature_control_o,
  input  wire logic [7:0]        palette_pixel_mask_o
);
  // --------------------------------------------------------------
  // helper decode
  // --------------------------------------------------------------
  logic [ADDR_W-1:0] off;
  logic [15:0]       p;
  logic              rd;
  logic              wr;
  assign off = io_space_i ? addr_i : addr_i - mmio_base_address_i;
  // out-of-range offsets fold onto ffff, which nothing decodes
  assign p   = (off[ADDR_W-1:16] == '0) ? off[15:0] : 16'hffff;
  assign rd  = req_i && !we_i;
  assign wr  = req_i && we_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  a_ack_after_req : assert property (
    req_i |=> ack_o) else $error("no ack after request");
  a_no_idle_ack : assert property (
    !req_i |=> !ack_o) else $error("ack without request");
  a_write_reads_zero : assert property (
    wr |=> rdata_o == 8'h00) else $error("read data on a write");
  a_status_one_read : assert property (
    rd && (p == 16'h03ba || p == 16'h03da) |=> rdata_o == $past(input_status_one_i))
    else $error("status one read wrong");
  a_status_zero_read : assert property (
    rd && p == 16'h03c2 |=> rdata_o == $past(input_status_zero_i)) else $error("status zero read wrong");
  a_misc_output_load : assert property (
    wr && p == 16'h03c2 |=> misc_output_o == $past(wdata_i)) else $error("misc output not loaded");
  a_feature_load : assert property (
    wr && (p == 16'h03ba || p == 16'h03da) |=> feature_control_o == $past(wdata_i))
    else $error("feature control not loaded");
  a_misc_readback : assert property (
    rd && p == 16'h03cc |=> rdata_o == misc_output_o) else $error("misc readback wrong");
  a_feature_read_only : assert property (
    wr && p == 16'h03ca |=> $stable(feature_control_o)) else $error("feature readback port written");
  a_pixel_mask_load : assert property (
    wr && p == 16'h03c6 |=> palette_pixel_mask_o == $past(wdata_i)) else $error("pixel mask not loaded");
  a_palette_write_pulse : assert property (
    wr && p == 16'h03c9 |=> palette_data_wr_o && palette_data_o == $past(wdata_i))
    else $error("palette data write missing");
endmodule : vga_port_register_decode_checker

bind vga_port_register_decode vga_port_register_decode_checker #(.ADDR_W(ADDR_W)) chk_i (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .we_i(we_i), .io_space_i(io_space_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .mmio_base_address_i(mmio_base_address_i),
  .input_status_zero_i(input_status_zero_i), .input_status_one_i(input_status_one_i),
  .ack_o(ack_o), .rdata_o(rdata_o), .palette_data_wr_o(palette_data_wr_o),
  .palette_data_o(palette_data_o), .misc_output_o(misc_output_o),
  .feature_control_o(feature_control_o), .palette_pixel_mask_o(palette_pixel_mask_o));
`default_nettype wire

// ---- host_model.sv ----
// host processor model issuing single-byte i/o and memory accesses
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [7:0]  rdata_i,
  output logic             req_o,
  output logic             we_o,
  output logic             io_space_o,
  output logic [31:0]      addr_o,
  output logic [7:0]       wdata_o
);
  initial
  begin
    req_o      = 1'b0;
    we_o       = 1'b0;
    io_space_o = 1'b1;
    addr_o     = 32'h0;
    wdata_o    = 8'h00;
  end

  // one request cycle, then a bounded wait for the answer
  task automatic access(input logic w, input logic io, input logic [31:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic late);
    late = 1'b1;
    q    = 8'h00;
    @(negedge clk_i);
    req_o      = 1'b1;
    we_o       = w;
    io_space_o = io;
    addr_o     = a;
    wdata_o    = d;
    // the request lasts one cycle; the answer stands only in the cycle after it is taken
    repeat (4)
    begin
      @(negedge clk_i);
      req_o   = 1'b0;
      // released lines do not keep the old value
      addr_o  = ~a;
      wdata_o = ~d;
      if (ack_i === 1'b1)
      begin
        q    = rdata_i;
        late = 1'b0;
        break;
      end
    end
  endtask : access
endmodule : host_model
`default_nettype wire

// ---- vga_port_register_decode_test.sv ----
// self-checking bench for the legacy display register port decoder
`timescale 1ns/100ps
`default_nettype none
module vga_port_register_decode_test;
  logic        clk;
  logic        arst_n;
  logic        req;
  logic        we;
  logic        io_space;
  logic [31:0] addr;
  logic [7:0]  wdata;
  logic [31:0] base;
  logic [7:0]  st0;
  logic [7:0]  st1;
  logic [7:0]  latch;
  logic [7:0]  pal_in;
  logic        ack;
  logic [7:0]  rdata;
  logic        pal_wr;
  logic        pal_rd;
  logic [7:0]  pal_out;
  logic [7:0]  misc;
  logic [7:0]  feat;
  logic [7:0]  mask;
  logic [7:0]  rd_idx;
  logic [7:0]  wr_idx;
  logic [7:0]  d;
  logic [15:0] pf;
  logic [7:0]  exp_d [26];
  logic [15:0] ip_w  [4] = '{16'h03c4, 16'h03ce, 16'h03d4, 16'h03d6};
  logic [15:0] ip_r  [4] = '{16'h03c4, 16'h03ce, 16'h03b4, 16'h03d6};
  logic [15:0] rsv   [4] = '{16'h03b0, 16'h03c3, 16'h03cb, 16'h03df};
  integer      seed = 84;
  int          err_total = 0;
  int          checks = 0;

  vga_port_register_decode vga_port_register_decode_i (
    .clk_i(clk), .arst_n_i(arst_n), .req_i(req), .we_i(we), .io_space_i(io_space), .addr_i(addr),
    .wdata_i(wdata), .mmio_base_address_i(base), .input_status_zero_i(st0), .input_status_one_i(st1),
    .memory_read_latch_i(latch), .palette_data_i(pal_in), .ack_o(ack), .rdata_o(rdata),
    .palette_data_wr_o(pal_wr), .palette_data_rd_o(pal_rd), .palette_data_o(pal_out), .misc_output_o(misc),
    .feature_control_o(feat), .palette_pixel_mask_o(mask), .palette_read_index_o(rd_idx),
    .palette_write_index_o(wr_idx));

  host_model host_model_i (
    .clk_i(clk), .ack_i(ack), .rdata_i(rdata), .req_o(req), .we_o(we), .io_space_o(io_space),
    .addr_o(addr), .wdata_o(wdata));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic test_done;
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // port reached through i/o space or as an offset from the base, at random
  task automatic acc(input logic w, input logic [15:0] p, input logic [7:0] wd, output logic [7:0] q);
    logic io;
    logic late;
    io = 1'($random(seed));
    host_model_i.access(w, io, io ? {16'h0, p} : base + {16'h0, p}, wd, q, late);
    if (late)
    begin
      err_total++;
      test_done;
    end
  endtask : acc

  task automatic wr(input logic [15:0] p, input logic [7:0] wd);
    logic [7:0] q;
    acc(1'b1, p, wd, q);
    check(q, 8'h00);
  endtask : wr

  task automatic rd(input logic [15:0] p, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, p, 8'h00, q);
    check(q, exp);
  endtask : rd

  function automatic logic vld(input int g, input int i);
    case (g)
      0:       return i <= 4 || i == 7;
      1:       return i <= 8 || i == 16 || i == 17 || i == 24;
      default: return g == 3 || i <= 24;
    endcase
  endfunction : vld

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    base   = 32'h0;
    st0    = $random(seed);
    st1    = $random(seed);
    latch  = $random(seed);
    pal_in = $random(seed);
    arst_n = 1'b0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    check(misc | feat | mask | rd_idx | wr_idx | pal_out, 8'h00);
    rd(16'h03c7, 8'h00);
    // fill indices 0 to 25 first so aliasing between indices shows up
    for (int g = 0; g < 4; g++)
    begin
      for (int i = 0; i < 26; i++)
      begin
        exp_d[i] = $random(seed);
        wr(ip_w[g], 8'(i));
        wr(ip_w[g] + 16'h1, exp_d[i]);
      end
      for (int i = 0; i < 26; i++)
      begin
        wr(ip_r[g], 8'(i));
        rd(ip_r[g], 8'(i));
        rd(ip_r[g] + 16'h1, vld(g, i) ? exp_d[i] : 8'h00);
      end
    end
    for (int i = 0; i < 22; i++)
    begin
      d = $random(seed);
      wr(16'h03c0, 8'(i));
      wr(16'h03d4, 8'h24);
      rd(16'h03d5, 8'h80);
      wr(16'h03c0, d);
      wr(16'h03c1, ~d);
      rd(16'h03d5, 8'h00);
      rd(16'h03c1, i <= 20 ? d : 8'h00);
      rd(16'h03c0, 8'(i));
    end
    for (int k = 0; k < 4; k++)
    begin
      base   = $random(seed) & 32'h7fff0000;
      st0    = $random(seed);
      st1    = $random(seed);
      latch  = $random(seed);
      pal_in = $random(seed);
      d      = $random(seed);
      pf     = k[0] ? 16'h03da : 16'h03ba;
      wr(16'h03c2, d);
      check(misc, d);
      wr(16'h03cc, ~d);
      rd(16'h03cc, d);
      rd(16'h03c2, st0);
      wr(pf, ~d);
      check(feat, ~d);
      wr(16'h03ca, d);
      rd(16'h03ca, ~d);
      rd(pf, st1);
      wr(16'h03c6, d);
      rd(16'h03c6, d);
      check(mask, d);
      wr(16'h03c7, ~d);
      check(rd_idx, ~d);
      rd(16'h03c7, 8'h03);
      wr(16'h03c8, d);
      rd(16'h03c7, 8'h00);
      rd(16'h03c8, d);
      check(wr_idx, d);
      wr(16'h03c9, ~d);
      check(pal_out, ~d);
      check({7'h00, pal_wr}, 8'h01);
      rd(16'h03c9, pal_in);
      check({7'h00, pal_rd}, 8'h01);
      wr(16'h03d4, 8'h22);
      rd(16'h03d5, latch);
      wr(rsv[k], 8'hff);
      rd(rsv[k], 8'h00);
      check(misc, d);
    end
    test_done;
  end
endmodule : vga_port_register_decode_test
`default_nettype wire
